// file: hw/mac_pkg.sv
// Purpose: constants and types for the multiply-accumulate slice
// Assumes: one clock, synchronous active-high resets
// Notes: register offsets are byte addresses on APB
// Contract
// - one 20-bit control word: opmode, alu code, carry, carry select, inmode
// - absent C operand reads as zero everywhere it is used
// - global reset, when chosen, drives every pipeline register reset
// - global enable, when chosen, drives every pipeline clock enable
// - adder runs as one 48, two 24 or four 12 bit lanes
// - carry out is 1, 2 or 4 bits, one per lane
// - lowest lane carry in bit 0, higher lanes in higher bits
// - pattern match high when unmasked result equals the pattern
// - inverse match high when unmasked result equals inverted pattern
// - overflow when result grows beyond P[N], N = mask ones, 1 to 46
// - underflow when result falls below minus P[N]
// - auto reset clears output register the cycle after a match
// - auto reset priority: reset (default) or output enable
// - pattern from C or 48-bit constant, equality on alu output
// - mask from C or 48-bit constant, set bits excluded
// - rounding masks: inverted C shifted left by 1 or by 2
// - wide xor of mux outputs, 12/24/48/96 bit groups, 12 default
// - A from input or cascade, B from input or cascade
// - pre-adder on 25-bit D, inmode bit 3 adds second input
// - multiplier A 27-bit and B 18-bit selectable from pre-adder
// - dynamic mode switches product and A:B concatenation per cycle
// - multiplier sign cascade out goes to next slice input; it is also readable as status register bit 8
// - each register reset clears its pipeline register when high
// - A cascade depth configurable, never above A path depth
package mac_pkg;
  // ===========================================================
  // register map
  localparam logic [11:0] CFG_ADDR  = 12'h000;
  localparam logic [11:0] PATL_ADDR = 12'h004;
  localparam logic [11:0] PATH_ADDR = 12'h008;
  localparam logic [11:0] MSKL_ADDR = 12'h00C;
  localparam logic [11:0] MSKH_ADDR = 12'h010;
  localparam logic [11:0] STAT_ADDR = 12'h014;
  localparam logic [31:0] CFG_RST   = 32'h0014_0010;
  localparam logic [47:0] PAT_RST   = 48'h0000_0000_0000;
  localparam logic [47:0] MSK_RST   = 48'h0000_0000_0000;
  // ===========================================================
  // config bit positions
  localparam int CFG_ASRC  = 0;
  localparam int CFG_BSRC  = 1;
  localparam int CFG_SIMD  = 2;
  localparam int CFG_CPRES = 4;
  localparam int CFG_GRST  = 5;
  localparam int CFG_GEN   = 6;
  localparam int CFG_AUTO  = 7;
  localparam int CFG_PRIO  = 8;
  localparam int CFG_PATC  = 9;
  localparam int CFG_MSEL  = 10;
  localparam int CFG_XW    = 12;
  localparam int CFG_PRSEL = 14;
  localparam int CFG_MAS   = 15;
  localparam int CFG_MBS   = 16;
  localparam int CFG_DYN   = 17;
  localparam int CFG_ADEP  = 18;
  localparam int CFG_ACDEP = 20;
  // ===========================================================
  // control word fields
  localparam int OPM_X    = 0;
  localparam int OPM_Y    = 2;
  localparam int OPM_Z    = 4;
  localparam int ALU_LSB  = 7;
  localparam int CIN_BIT  = 11;
  localparam int CSEL_LSB = 12;
  localparam int INM_LSB  = 15;
  localparam int INM_PRE  = 3;
  localparam logic [3:0] ALU_ADD = 4'h0;
  localparam logic [3:0] ALU_SUB = 4'h3;
  localparam logic [3:0] ALU_XOR = 4'h4;
  localparam logic [3:0] ALU_AND = 4'hC;
  localparam logic [5:0] N_MIN   = 6'h01;
  localparam logic [5:0] N_MAX   = 6'h2E;
  typedef enum logic [1:0] {
    SIMD_ONE48  = 2'h0,
    SIMD_TWO24  = 2'h1,
    SIMD_FOUR12 = 2'h2
  } simd_t;
  typedef struct packed {
    logic a, b, c, d, m, p, ctrl;
  } reg_ctl_t;
  typedef struct packed {
    logic [31:0] cfg;
    logic [47:0] pat, msk;
    logic [31:0] prdata;
    logic        pready, pslverr;
    logic [29:0] a1, a2, acq;
    logic [17:0] b1, bco;
    logic [47:0] c1;
    logic [24:0] d1;
    logic [44:0] m1;
    logic [19:0] ctl;
    logic [47:0] p;
    logic [3:0]  cy;
    logic        pm, pim, ovf, unf, ms;
    logic [7:0]  xo;
  } state_t;
endpackage : mac_pkg

// file: hw/mac_slice.sv
// Purpose: multiply-accumulate slice with simd adder and pattern detect
// Assumes: inputs synchronous to core_clk, APB master per protocol
// Notes: all outputs come from the single state register
`timescale 1ns/1ps
module mac_slice
#(
  parameter logic [31:0] CFG_INIT = mac_pkg::CFG_RST
)
(
  input  wire logic              core_clk,
  input  wire logic              srst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output      logic [31:0]       prdata,
  output      logic              pready,
  output      logic              pslverr,
  input  wire logic [29:0]       a_in,
  input  wire logic [29:0]       acin,
  input  wire logic [17:0]       b_in,
  input  wire logic [17:0]       bcin,
  input  wire logic [47:0]       c_in,
  input  wire logic [24:0]       d_in,
  input  wire logic [47:0]       pcin,
  input  wire logic [19:0]       ctrl_word,
  input  wire logic              carry_casc_in,
  input  wire logic              rst_all,
  input  wire logic              en_all,
  input  wire mac_pkg::reg_ctl_t rst_vec,
  input  wire mac_pkg::reg_ctl_t ce_vec,
  output      logic [47:0]       p_out,
  output      logic [3:0]        carry_out,
  output      logic              pattern_match,
  output      logic              pattern_inv_match,
  output      logic              overflow,
  output      logic              underflow,
  output      logic [29:0]       acout,
  output      logic [17:0]       bcout,
  output      logic [7:0]        xor_out,
  output      logic              mult_sign_out
);
  // ===========================================================
  // functions
  function automatic logic [51:0] simd_add(
    input logic [47:0] z,
    input logic [47:0] x,
    input logic [47:0] y,
    input logic        ci,
    input logic [1:0]  md
  );
    logic [13:0] t;
    logic [1:0]  cc;
    logic [47:0] s;
    logic [3:0]  lc;
    logic [3:0]  co;
    cc = {1'b0, ci};
    s  = '0;
    lc = '0;
    for (int i = 0; i < 4; i++)
    begin
      t = {2'b00, z[i*12+:12]} + {2'b00, x[i*12+:12]}
        + {2'b00, y[i*12+:12]} + {12'h000, cc};
      s[i*12+:12] = t[11:0];
      lc[i] = |t[13:12];
      // no carry crosses a lane edge
      if (md == mac_pkg::SIMD_FOUR12 ||
          (md == mac_pkg::SIMD_TWO24 && i == 1))
        cc = 2'b00;
      else
        cc = t[13:12];
    end
    case (md)
      mac_pkg::SIMD_TWO24:  co = {2'b00, lc[3], lc[1]};
      mac_pkg::SIMD_FOUR12: co = lc;
      default:              co = {3'b000, lc[3]};
    endcase
    return {co, s};
  endfunction : simd_add

  function automatic logic [5:0] ones(input logic [47:0] v);
    logic [5:0] n;
    n = '0;
    for (int i = 0; i < 48; i++)
      n = n + {5'h00, v[i]};
    return n;
  endfunction : ones

  // ===========================================================
  // state and decode
  mac_pkg::state_t   st;
  mac_pkg::state_t   next_st;
  mac_pkg::reg_ctl_t rr;
  mac_pkg::reg_ctl_t ee;
  logic [29:0] a_src;
  logic [29:0] a_q;
  logic [29:0] ac_tap;
  logic [17:0] b_q;
  logic [1:0]  adep;
  logic [1:0]  acdep;
  logic [26:0] sec;
  logic [26:0] ad;
  logic [26:0] ma;
  logic [17:0] mb;
  logic signed [44:0] prod;
  logic [47:0] xm;
  logic [47:0] ym;
  logic [47:0] zm;
  logic [47:0] pat;
  logic [47:0] msk;
  logic [47:0] alu;
  logic [51:0] sum;
  logic [3:0]  cy;
  logic        cin;
  logic [3:0]  fn;
  logic [5:0]  n;
  logic signed [47:0] sh;
  logic [7:0]  g;
  logic [95:0] xv;
  logic        clr_auto;
  logic        wr;
  logic [31:0] rd;
  logic        hit;

  wire [31:0] cfg = st.cfg;
  wire [1:0]  simd = cfg[mac_pkg::CFG_SIMD+:2];
  wire [19:0] ctl = st.ctl;

  // a global line fans out to every pipeline register of the slice
  assign rr = cfg[mac_pkg::CFG_GRST] ?
              mac_pkg::reg_ctl_t'({7{rst_all}}) : rst_vec;
  assign ee = cfg[mac_pkg::CFG_GEN] ?
              mac_pkg::reg_ctl_t'({7{en_all}}) : ce_vec;

  // ===========================================================
  // operand path
  always_comb
  begin
    a_src = cfg[mac_pkg::CFG_ASRC] ? acin : a_in;
    adep  = (cfg[mac_pkg::CFG_ADEP+:2] == 2'h3) ? 2'h2 :
            cfg[mac_pkg::CFG_ADEP+:2];
    // cascade tap may never sit deeper than the A path
    acdep = (cfg[mac_pkg::CFG_ACDEP+:2] > adep) ? adep :
            cfg[mac_pkg::CFG_ACDEP+:2];
    case (adep)
      2'h0:    a_q = a_src;
      2'h1:    a_q = st.a1;
      default: a_q = st.a2;
    endcase
    case (acdep)
      2'h0:    ac_tap = a_src;
      2'h1:    ac_tap = st.a1;
      default: ac_tap = st.a2;
    endcase
    b_q = st.b1;
    sec = cfg[mac_pkg::CFG_PRSEL] ? {{9{b_q[17]}}, b_q} : a_q[26:0];
    ad  = {{2{st.d1[24]}}, st.d1}
        + (ctl[mac_pkg::INM_LSB + mac_pkg::INM_PRE] ? sec
                                                     : 27'h0000000);
    ma = cfg[mac_pkg::CFG_MAS] ? ad : a_q[26:0];
    mb = cfg[mac_pkg::CFG_MBS] ? ad[17:0] : b_q;
  end

  assign prod = $signed(ma) * $signed(mb);

  // ===========================================================
  // alu path
  always_comb
  begin
    case (ctl[mac_pkg::OPM_X+:2])
      2'h1:    xm = {{3{st.m1[44]}}, st.m1};
      2'h2:    xm = st.p;
      // concatenation only reachable in dynamic mode
      2'h3:    xm = cfg[mac_pkg::CFG_DYN] ? {a_q, b_q}
                    : {{3{st.m1[44]}}, st.m1};
      default: xm = '0;
    endcase
    case (ctl[mac_pkg::OPM_Y+:2])
      2'h2:    ym = '1;
      2'h3:    ym = st.c1;
      default: ym = '0;
    endcase
    case (ctl[mac_pkg::OPM_Z+:3])
      3'h1:    zm = pcin;
      3'h2:    zm = st.p;
      3'h3:    zm = st.c1;
      default: zm = '0;
    endcase
    case (ctl[mac_pkg::CSEL_LSB+:3])
      3'h0:    cin = ctl[mac_pkg::CIN_BIT];
      3'h1:    cin = carry_casc_in;
      default: cin = 1'b0;
    endcase
    fn = ctl[mac_pkg::ALU_LSB+:4];
    case (fn)
      mac_pkg::ALU_SUB:
      begin
        sum = simd_add(~zm, xm, ym, cin, simd);
        alu = ~sum[47:0];
        cy  = sum[51:48];
      end
      mac_pkg::ALU_XOR:
      begin
        sum = '0;
        alu = xm ^ zm;
        cy  = '0;
      end
      mac_pkg::ALU_AND:
      begin
        sum = '0;
        alu = xm & zm;
        cy  = '0;
      end
      default:
      begin
        sum = simd_add(zm, xm, ym, cin, simd);
        alu = sum[47:0];
        cy  = sum[51:48];
      end
    endcase
  end

  // ===========================================================
  // pattern, mask, limits, wide xor
  always_comb
  begin
    pat = cfg[mac_pkg::CFG_PATC] ? st.c1 : st.pat;
    case (cfg[mac_pkg::CFG_MSEL+:2])
      2'h1:    msk = st.c1;
      2'h2:    msk = ~st.c1 << 1;
      2'h3:    msk = ~st.c1 << 2;
      default: msk = st.msk;
    endcase
    n = ones(msk);
    if (n < mac_pkg::N_MIN)
      n = mac_pkg::N_MIN;
    else if (n > mac_pkg::N_MAX)
      n = mac_pkg::N_MAX;
    sh = $signed(alu) >>> n;
    xv = {xm, zm};
    for (int i = 0; i < 8; i++)
      g[i] = ^xv[i*12+:12];
  end

  // ===========================================================
  // apb decode
  always_comb
  begin
    hit = 1'b1;
    case (paddr)
      mac_pkg::CFG_ADDR:  rd = st.cfg;
      mac_pkg::PATL_ADDR: rd = st.pat[31:0];
      mac_pkg::PATH_ADDR: rd = {16'h0000, st.pat[47:32]};
      mac_pkg::MSKL_ADDR: rd = st.msk[31:0];
      mac_pkg::MSKH_ADDR: rd = {16'h0000, st.msk[47:32]};
      mac_pkg::STAT_ADDR: rd = {23'h000000, st.ms, st.cy,
                                st.unf, st.ovf, st.pim, st.pm};
      default:
      begin
        rd  = '0;
        hit = 1'b0;
      end
    endcase
  end

  assign wr = psel & penable & pwrite & st.pready;
  // reset priority clears regardless of the output enable
  assign clr_auto = cfg[mac_pkg::CFG_AUTO] & st.pm
                  & (~cfg[mac_pkg::CFG_PRIO] | ee.p);

  // ===========================================================
  // next state
  always_comb
  begin
    next_st = st;
    // one wait-free access: answer in the first access cycle
    next_st.pready  = psel & ~penable;
    next_st.pslverr = psel & ~penable & ~hit;
    if (psel & ~penable)
      next_st.prdata = rd;
    if (wr)
    begin
      case (paddr)
        mac_pkg::CFG_ADDR:  next_st.cfg = pwdata;
        mac_pkg::PATL_ADDR: next_st.pat[31:0] = pwdata;
        mac_pkg::PATH_ADDR: next_st.pat[47:32] = pwdata[15:0];
        mac_pkg::MSKL_ADDR: next_st.msk[31:0] = pwdata;
        mac_pkg::MSKH_ADDR: next_st.msk[47:32] = pwdata[15:0];
        default:            next_st.cfg = st.cfg;
      endcase
    end
    if (rr.a)
    begin
      next_st.a1  = '0;
      next_st.a2  = '0;
      next_st.acq = '0;
    end
    else if (ee.a)
    begin
      next_st.a1  = a_src;
      next_st.a2  = st.a1;
      next_st.acq = ac_tap;
    end
    if (rr.b)
    begin
      next_st.b1  = '0;
      next_st.bco = '0;
    end
    else if (ee.b)
    begin
      next_st.b1  = cfg[mac_pkg::CFG_BSRC] ? bcin : b_in;
      next_st.bco = st.b1;
    end
    if (rr.c)
      next_st.c1 = '0;
    else if (ee.c)
      next_st.c1 = cfg[mac_pkg::CFG_CPRES] ? c_in : 48'h0;
    if (rr.d)
      next_st.d1 = '0;
    else if (ee.d)
      next_st.d1 = d_in;
    if (rr.m)
      next_st.m1 = '0;
    else if (ee.m)
      next_st.m1 = prod;
    if (rr.ctrl)
      next_st.ctl = '0;
    else if (ee.ctrl)
      next_st.ctl = ctrl_word;
    if (rr.p)
    begin
      next_st.p   = '0;
      next_st.cy  = '0;
      next_st.pm  = 1'b0;
      next_st.pim = 1'b0;
      next_st.ovf = 1'b0;
      next_st.unf = 1'b0;
      next_st.xo  = '0;
      next_st.ms  = 1'b0;
    end
    else
    begin
      if (ee.p)
      begin
        next_st.p   = alu;
        next_st.cy  = cy;
        next_st.pm  = &(~(alu ^ pat) | msk);
        next_st.pim = &(~(alu ^ ~pat) | msk);
        next_st.ovf = ~alu[47] & (|sh);
        next_st.unf = alu[47] & ~(&sh);
        next_st.ms  = st.m1[44];
        case (cfg[mac_pkg::CFG_XW+:2])
          2'h1: next_st.xo = {4'h0, g[7] ^ g[6], g[5] ^ g[4],
                              g[3] ^ g[2], g[1] ^ g[0]};
          2'h2: next_st.xo = {6'h00, ^g[7:4], ^g[3:0]};
          2'h3: next_st.xo = {7'h00, ^g};
          default: next_st.xo = g;
        endcase
      end
      if (clr_auto)
        next_st.p = '0;
    end
    if (srst)
    begin
      next_st     = '0;
      next_st.cfg = CFG_INIT;
      next_st.pat = mac_pkg::PAT_RST;
      next_st.msk = mac_pkg::MSK_RST;
    end
  end

  always_ff @(posedge core_clk)
    st <= next_st;

  assign prdata            = st.prdata;
  assign pready            = st.pready;
  assign pslverr           = st.pslverr;
  assign p_out             = st.p;
  assign carry_out         = st.cy;
  assign pattern_match     = st.pm;
  assign pattern_inv_match = st.pim;
  assign overflow          = st.ovf;
  assign underflow         = st.unf;
  assign acout             = st.acq;
  assign bcout             = st.bco;
  assign xor_out           = st.xo;
  assign mult_sign_out     = st.ms;

  // ===========================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  auto_clear_a:
  assert property (cfg[mac_pkg::CFG_AUTO] && !cfg[mac_pkg::CFG_PRIO]
                   && pattern_match && !wr |=> p_out == 48'h0)
    else $error("auto reset did not clear output");
  prio_hold_a:
  assert property (cfg[mac_pkg::CFG_PRIO] && pattern_match && !ee.p
                   && !rr.p && !wr |=> $stable(p_out))
    else $error("enable priority cleared without enable");
  one_lane_cy_a:
  assert property (simd == mac_pkg::SIMD_ONE48 && ee.p && !wr
                   |=> carry_out[3:1] == 3'b000)
    else $error("extra carry bits in single lane mode");
  two_lane_cy_a:
  assert property (simd == mac_pkg::SIMD_TWO24 && ee.p && !wr
                   |=> carry_out[3:2] == 2'b00)
    else $error("carry in wrong bit in dual lane mode");
  c_absent_a:
  assert property (!cfg[mac_pkg::CFG_CPRES] && !wr
                   |=> st.c1 == 48'h0)
    else $error("absent c operand not zero");
  glob_rst_a:
  assert property (cfg[mac_pkg::CFG_GRST] && rst_all && !wr
                   |=> p_out == 48'h0 && acout == 30'h0 && bcout == 18'h0)
    else $error("global reset missed a register");
  glob_en_a:
  assert property (cfg[mac_pkg::CFG_GEN] && !cfg[mac_pkg::CFG_GRST]
                   && !en_all && !rr.a && !rr.b && !wr
                   |=> $stable(acout) && $stable(bcout))
    else $error("register moved with global enable low");
  pat_eq_a:
  assert property (pattern_match && $stable(st.cfg) && !cfg[mac_pkg::CFG_AUTO]
                   && !cfg[mac_pkg::CFG_PATC]
                   && cfg[mac_pkg::CFG_MSEL+:2] == 2'h0
                   && $stable(st.pat) && $stable(st.msk)
                   |-> &(~(p_out ^ st.pat) | st.msk))
    else $error("match flag without equality");
  inv_eq_a:
  assert property (pattern_inv_match && $stable(st.cfg)
                   && !cfg[mac_pkg::CFG_AUTO] && !cfg[mac_pkg::CFG_PATC]
                   && cfg[mac_pkg::CFG_MSEL+:2] == 2'h0
                   && $stable(st.pat) && $stable(st.msk)
                   |-> &(~(p_out ^ ~st.pat) | st.msk))
    else $error("inverse match flag without equality");
  acout_tap_a:
  assert property (cfg[mac_pkg::CFG_ACDEP+:2] == 2'h0 && ee.a && !rr.a
                   && !wr |=> acout == $past(a_src))
    else $error("cascade tap deeper than selected");
  xor_width_a:
  assert property (cfg[mac_pkg::CFG_XW+:2] == 2'h3 && ee.p && !wr
                   |=> xor_out[7:1] == 7'h00)
    else $error("wide xor width not honoured");
  apb_ready_a:
  assert property (psel && !penable |=> pready ##1 !pready)
    else $error("apb answer timing wrong");
endmodule : mac_slice

// file: testbench/slice_neighbour.sv
// Purpose: neighbouring slice feeding the cascade inputs
// Assumes: neighbour outputs are registered on core_clk
// Notes: the bench sets its values; our cascade outs are only observed
`timescale 1ns/1ps
module slice_neighbour
(
  input  wire logic        core_clk,
  input  wire logic [29:0] a_val,
  input  wire logic [17:0] b_val,
  input  wire logic [47:0] p_val,
  input  wire logic        cy_val,
  input  wire logic        sign_in,
  output      logic [29:0] acin,
  output      logic [17:0] bcin,
  output      logic [47:0] pcin,
  output      logic        carry_casc_in,
  output      logic        sign_seen
);
  // ======================================
  // registered, as a real slice's cascade outputs are
  always_ff @(posedge core_clk)
  begin
    acin          <= a_val;
    bcin          <= b_val;
    pcin          <= p_val;
    carry_casc_in <= cy_val;
    sign_seen     <= sign_in;
  end
endmodule : slice_neighbour

// file: testbench/mac_slice_test.sv
// Purpose: self-checking bench for the mac slice
// Assumes: apb answers in the first access cycle
// Notes: results are read once the three-stage pipeline has settled
`timescale 1ns/1ps
module mac_slice_test;
  localparam logic [31:0] CR = mac_pkg::CFG_RST;
  localparam logic [19:0] CP = 20'h00030;
  localparam logic [7:0]  XE [4] = '{8'h15, 8'h07, 8'h02, 8'h01};
  logic              core_clk = 1'b0;
  logic              srst = 1'b1;
  logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0]       paddr = 12'h000;
  logic [31:0]       pwdata = 32'h0, prdata;
  logic              pready, pslverr, carry_casc_in;
  logic [29:0]       a_in = 30'h0, acin, acout, nb_a = 30'h0;
  logic [17:0]       b_in = 18'h0, bcin, bcout, nb_b = 18'h0;
  logic [47:0]       c_in = 48'h0, pcin, p_out, nb_p = 48'h0;
  logic [24:0]       d_in = 25'h0;
  logic [19:0]       ctrl_word = 20'h0;
  logic              rst_all = 1'b0, en_all = 1'b1, nb_cy = 1'b0;
  mac_pkg::reg_ctl_t rst_vec = 7'h00, ce_vec = 7'h7F;
  logic [3:0]        carry_out;
  logic              pattern_match, pattern_inv_match;
  logic              overflow, underflow, mult_sign_out, sign_seen;
  logic [7:0]        xor_out;
  int                failures = 0, n_checks = 0, cyc = 0;

  mac_slice i_dut (.core_clk, .srst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .a_in, .acin, .b_in, .bcin,
    .c_in, .d_in, .pcin, .ctrl_word, .carry_casc_in, .rst_all, .en_all,
    .rst_vec, .ce_vec, .p_out, .carry_out, .pattern_match,
    .pattern_inv_match, .overflow, .underflow, .acout, .bcout, .xor_out,
    .mult_sign_out);
  slice_neighbour i_nb (.core_clk, .a_val(nb_a), .b_val(nb_b),
    .p_val(nb_p), .cy_val(nb_cy), .sign_in(mult_sign_out), .acin, .bcin,
    .pcin, .carry_casc_in, .sign_seen);

  always #4 core_clk = ~core_clk;
  // a hang ends the run long before the simulator would
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      failures++;
      report_and_stop();
    end
  end

  // ======================================
  // shared tasks
  task chk(input logic [47:0] got, input logic [47:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: %h, expected %h", $time, got, exp);
    end
  endtask : chk

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1)
      @(posedge core_clk);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb

  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x);
    chk(e, xe);
  endtask : rd

  task setpm(input logic [47:0] pt, input logic [47:0] mk);
    wr(mac_pkg::PATL_ADDR, pt[31:0]);
    wr(mac_pkg::PATH_ADDR, {16'h0, pt[47:32]});
    wr(mac_pkg::MSKL_ADDR, mk[31:0]);
    wr(mac_pkg::MSKH_ADDR, {16'h0, mk[47:32]});
  endtask : setpm

  // fixed wait: the pipeline is three edges deep
  task run(input logic [31:0] cfg, input logic [19:0] cw,
           input logic [47:0] c);
    wr(mac_pkg::CFG_ADDR, cfg);
    ctrl_word <= cw;
    c_in      <= c;
    repeat (5) @(posedge core_clk);
  endtask : run

  // ======================================
  // scenarios
  task t_regs;
    rd(mac_pkg::CFG_ADDR, CR, 1'b0);
    rd(mac_pkg::PATL_ADDR, 32'h0, 1'b0);
    rd(12'h018, 32'h0, 1'b1);
    wr(mac_pkg::MSKL_ADDR, 32'hA5A5_0F0F);
    rd(mac_pkg::MSKL_ADDR, 32'hA5A5_0F0F, 1'b0);
  endtask : t_regs

  task t_mult;
    d_in <= 25'h2;
    a_in <= 30'h3;
    b_in <= 18'h5;
    run(CR, 20'h00001, 48'h0);
    chk(p_out, 48'hF);
    b_in <= 18'h7;
    run(CR | 32'h8000, 20'h40001, 48'h0);
    chk(p_out, 48'h23);
    run(CR | 32'h8000, 20'h00001, 48'h0);
    chk(p_out, 48'hE);
    run(CR | 32'hC000, 20'h40001, 48'h0);
    chk(p_out, 48'h3F);
    run(CR | 32'h10000, 20'h40001, 48'h0);
    chk(p_out, 48'hF);
    a_in <= 30'h1;
    b_in <= 18'h2;
    run(CR | 32'h20000, 20'h00003, 48'h0);
    chk(p_out, 48'h4_0002);
    run(CR | 32'h20000, 20'h00001, 48'h0);
    chk(p_out, 48'h2);
  endtask : t_mult

  task t_simd;
    run(CR, 20'h0003C, 48'h8018_007F_FFFF);
    chk(p_out, 48'h0030_00FF_FFFE);
    chk(carry_out[0], 1'b1);
    run(CR | 32'h4, 20'h0003C, 48'h8018_007F_FFFF);
    chk(p_out, 48'h0030_00FF_FFFE);
    chk(carry_out[1:0], 2'b10);
    run(CR | 32'h8, 20'h0003C, 48'h8018_007F_FFFF);
    chk(p_out, 48'h0020_00FF_EFFE);
    chk(carry_out, 4'b1101);
    // a small product puts ones in the x half of the wide xor
    a_in <= 30'h1;
    b_in <= 18'h2;
    for (int i = 0; i < 4; i++)
    begin
      run(CR | (32'(i) << 12), 20'h00031, 48'h0030_0100_0001);
      chk(xor_out, XE[i]);
    end
  endtask : t_simd

  task t_ctl;
    a_in <= 30'h1;
    b_in <= 18'h2;
    run(CR, 20'h001B8, 48'h5);
    chk(p_out, 48'h6);
    run(CR, 20'h00231, 48'h6);
    chk(p_out, 48'h4);
    run(CR, 20'h00631, 48'h6);
    chk(p_out, 48'h2);
    run(CR, 20'h00830, 48'h5);
    chk(p_out, 48'h6);
    nb_cy <= 1'b1;
    run(CR, 20'h01030, 48'h5);
    chk(p_out, 48'h6);
    nb_cy <= 1'b0;
    run(CR & 32'hFFFF_FFEF, CP, 48'h5);
    chk(p_out, 48'h0);
    rst_all <= 1'b1;
    run(CR | 32'h20, CP, 48'h5);
    chk(p_out, 48'h0);
    rst_all <= 1'b0;
    run(CR | 32'h40, CP, 48'h5);
    en_all <= 1'b0;
    run(CR | 32'h40, CP, 48'h9);
    chk(p_out, 48'h5);
    en_all  <= 1'b1;
    rst_vec <= 7'h02;
    run(CR, CP, 48'h9);
    chk(p_out, 48'h0);
    rst_vec <= 7'h00;
  endtask : t_ctl

  task t_pat;
    setpm(48'h0000_1234_5678, 48'h0);
    run(CR, CP, 48'h0000_1234_5678);
    chk(pattern_match, 1'b1);
    chk(pattern_inv_match, 1'b0);
    rd(mac_pkg::STAT_ADDR, 32'h0000_0005, 1'b0);
    ce_vec <= 7'h7D;
    run(CR | 32'h180, CP, 48'h0000_1234_5678);
    chk(p_out, 48'h1234_5678);
    run(CR | 32'h80, CP, 48'h0000_1234_5678);
    chk(p_out, 48'h0);
    ce_vec <= 7'h7F;
    run(CR, CP, 48'hFFFF_EDCB_A987);
    chk(pattern_inv_match, 1'b1);
    chk(pattern_match, 1'b0);
    setpm(48'h0000_1234_5678, 48'hF);
    run(CR, CP, 48'h0000_1234_567F);
    chk(pattern_match, 1'b1);
    run(CR | 32'h200, CP, 48'h0000_0000_0ABC);
    chk(pattern_match, 1'b1);
    setpm(48'h0, 48'h0);
    run(CR | 32'h800, CP, 48'h2);
    chk(pattern_match, 1'b1);
    run(CR | 32'hC00, CP, 48'h2);
    chk(pattern_match, 1'b0);
    run(CR | 32'h400, CP, 48'hF0);
    chk(pattern_match, 1'b1);
    setpm(48'h0, 48'hFF);
    run(CR, CP, 48'h100);
    chk(overflow, 1'b1);
    run(CR, CP, 48'hFF);
    chk(overflow, 1'b0);
    run(CR, CP, 48'hFFFF_FFFF_FF00);
    chk(underflow, 1'b0);
    run(CR, CP, 48'hFFFF_FFFF_FEFF);
    chk(underflow, 1'b1);
  endtask : t_pat

  task t_casc;
    nb_a <= 30'h6;
    nb_b <= 18'h7;
    a_in <= 30'h1;
    b_in <= 18'h1;
    run(CR | 32'h3, 20'h00001, 48'h0);
    chk(p_out, 48'h2A);
    chk(acout, 30'h6);
    chk(bcout, 18'h7);
    chk(sign_seen, 1'b0);
    nb_a <= 30'h3FFF_FFFF;
    run(CR | 32'h3, 20'h00001, 48'h0);
    chk(p_out, 48'hFFFF_FFFF_FFF9);
    chk(sign_seen, 1'b1);
    run(32'h0004_0013, 20'h00001, 48'h0);
    chk(acout, 30'h3FFF_FFFF);
    nb_p <= 48'h1234_0000_ABCD;
    run(CR, 20'h00010, 48'h0);
    chk(p_out, 48'h1234_0000_ABCD);
  endtask : t_casc

  task report_and_stop;
    $display("checks %0d, failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  initial
  begin
    repeat (10) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    t_regs();
    t_mult();
    t_simd();
    t_ctl();
    t_pat();
    t_casc();
    report_and_stop();
  end
endmodule : mac_slice_test
